/* File: tb_top.sv */
// self-checking bench of the date switch with a clock model
// assumes one clock domain and dates as year-2000, month, day
`timescale 1ns/10ps
module tb_top import tmds_pkg::*;;
  logic        ref_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        go = 1'b0;
  logic        mid = 1'b1;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] cdate = 16'h0021;
  logic [15:0] on_v = 16'h0021;
  logic [15:0] off_v = 16'h0021;
  logic [2:0]  md_v = 3'h0;
  logic [3:0]  addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] rv;
  logic [31:0] lfsr = 32'h3535;
  logic [31:0] rdata_o;
  logic        tick_i;
  logic        q_o;
  logic [6:0]  cal_year_i;
  logic [3:0]  cal_month_i;
  logic [4:0]  cal_day_i;
  logic [4:0]  cal_hour_i;
  logic [5:0]  cal_min_i;
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc = 0;

  tmds_cal_src tmds_cal_src_inst (.ref_clk_i(ref_clk_i), .go_i(go), .date_i(cdate), .mid_i(mid), .tick_o(tick_i),
    .year_o(cal_year_i), .month_o(cal_month_i), .day_o(cal_day_i), .hour_o(cal_hour_i), .min_o(cal_min_i));
  tmds_top tmds_top_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .tick_i(tick_i), .cal_year_i(cal_year_i),
    .cal_month_i(cal_month_i), .cal_day_i(cal_day_i), .cal_hour_i(cal_hour_i), .cal_min_i(cal_min_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .q_o(q_o));

  // ************
  // helpers
  // ************
  always #5 ref_clk_i = ~ref_clk_i;

  // whole run needs about 1300 cycles
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      complete_run();
    end
  end

  function automatic logic [15:0] dt(input int y, input int m, input int d);
    dt = {y[6:0], m[3:0], d[4:0]};
  endfunction : dt

  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  // off date exclusive; monthly wins over yearly
  function automatic logic win(input logic [2:0] m, input logic [15:0] a, input logic [15:0] b, input logic [15:0] d);
    logic [6:0] y;
    logic       iy;
    y = d[15:9];
    iy = (y >= a[15:9]) && (y <= b[15:9]);
    if (m[0] && a[4:0] < b[4:0])
      win = iy && d[4:0] >= a[4:0] && d[4:0] < b[4:0];
    else if (m[0])
      win = iy && ((d[4:0] >= a[4:0] && !(y == b[15:9] && d[8:5] == 4'hC))
            || (d[4:0] < b[4:0] && !(y == a[15:9] && d[8:5] == 4'h1)));
    else if (m[1] && a[8:0] < b[8:0])
      win = iy && d[8:0] >= a[8:0] && d[8:0] < b[8:0];
    else if (m[1])
      win = (d[8:0] >= a[8:0] && y >= a[15:9] && y < b[15:9]) || (d[8:0] < b[8:0] && y > a[15:9] && y <= b[15:9]);
    else
      win = d >= a && d < b;
  endfunction : win

  task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL rdata exp %h got %h", e, g);
    end
  endtask : chk_reg

  task automatic chk_q(input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL q exp %b got %b date %h", e, g, cdate);
    end
  endtask : chk_q

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd

  task automatic cfg(input logic [2:0] m, input logic [15:0] a, input logic [15:0] b);
    md_v = m;
    on_v = a;
    off_v = b;
    wr(ADDR_ON_DATE, {16'h0000, a});
    wr(ADDR_OFF_DATE, {16'h0000, b});
    wr(ADDR_MODE, {29'h0, m});
  endtask : cfg

  // one reading from the clock, then q is compared
  task automatic day(input logic [15:0] d, input logic m, input logic e);
    @(posedge ref_clk_i);
    go <= 1'b1;
    cdate <= d;
    mid <= m;
    @(posedge ref_clk_i);
    go <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1 chk_q(e, q_o);
  endtask : day

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // ************
  // main sequence
  // ************
  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rd(ADDR_ON_DATE, rv);
    chk_reg({16'h0000, ON_RST}, rv);
    wr(ADDR_ON_DATE, 32'h0000_01A1);
    wr(ADDR_OFF_DATE, 32'h0000_C821);
    rd(ADDR_ON_DATE, rv);
    chk_reg(32'h0000_0021, rv);
    rd(ADDR_STATUS, rv);
    chk_reg(32'h0000_0004, rv);
    wr(ADDR_STATUS, 32'h0000_0004);
    wr(ADDR_OFF_DATE, 32'h0000_C79F);
    rd(ADDR_OFF_DATE, rv);
    chk_reg(32'h0000_C79F, rv);
    rd(4'h2, rv);
    chk_reg(32'h0, rv);
    $display("test registers done");
    cfg(3'h0, dt(8, 6, 1), dt(10, 8, 31));
    day(dt(8, 5, 31), 1'b1, 1'b0);
    day(dt(8, 6, 1), 1'b1, 1'b1);
    rd(ADDR_STATUS, rv);
    chk_reg(32'h0000_0003, rv);
    day(dt(10, 8, 31), 1'b0, 1'b1);
    day(dt(10, 8, 31), 1'b1, 1'b0);
    $display("test single period done");
    cfg(3'h2, dt(8, 12, 15), dt(10, 1, 7));
    foreach (rv[i])
    begin
      if (i < 8)
        day(dt(8 + i / 3, (i % 2) ? 1 : 12, 14 - (i % 3) * 7 + (i % 2) * 1), 1'b1, 1'b0 | win(md_v, on_v, off_v,
          dt(8 + i / 3, (i % 2) ? 1 : 12, 14 - (i % 3) * 7 + (i % 2) * 1)));
    end
    cfg(3'h1, dt(8, 1, 1), dt(10, 1, 5));
    day(dt(8, 3, 1), 1'b1, 1'b1);
    day(dt(8, 3, 5), 1'b1, 1'b0);
    day(dt(10, 12, 4), 1'b1, 1'b1);
    day(dt(11, 1, 1), 1'b1, 1'b0);
    $display("test repeat modes done");
    repeat (24)
    begin
      lfsr = nxt(lfsr);
      cfg({1'b0, lfsr[1:0]}, dt(lfsr[4:2], lfsr[8:5] % 12 + 1, lfsr[13:9] % 28 + 1),
        dt(lfsr[16:14] + 2, lfsr[20:17] % 12 + 1, lfsr[25:21] % 28 + 1));
      repeat (8)
      begin
        lfsr = nxt(lfsr);
        day(dt(lfsr[3:0] % 11, lfsr[7:4] % 12 + 1, lfsr[12:8] % 28 + 1), 1'b1,
          win(md_v, on_v, off_v, dt(lfsr[3:0] % 11, lfsr[7:4] % 12 + 1, lfsr[12:8] % 28 + 1)));
      end
    end
    $display("test random done");
    cfg(3'h4, dt(8, 3, 15), dt(9, 1, 1));
    day(dt(8, 3, 14), 1'b1, 1'b0);
    day(dt(8, 3, 15), 1'b1, 1'b1);
    day(dt(8, 3, 15), 1'b0, 1'b0);
    day(dt(8, 3, 16), 1'b1, 1'b0);
    day(dt(8, 3, 15), 1'b1, 1'b0);
    cfg(3'h6, dt(8, 3, 15), dt(10, 1, 1));
    day(dt(9, 3, 14), 1'b1, 1'b0);
    day(dt(10, 3, 15), 1'b1, 1'b1);
    day(dt(10, 3, 16), 1'b1, 1'b0);
    day(dt(11, 3, 15), 1'b1, 1'b0);
    cfg(3'h5, dt(8, 3, 15), dt(10, 1, 1));
    day(dt(9, 4, 15), 1'b1, 1'b1);
    $display("test pulse done");
    complete_run();
  end
endmodule : tb_top

/* File: tmds_cal_src.sv */
// calendar date source model feeding the date switch
// assumes the bench asks for one new reading at a time
`timescale 1ns/10ps
module tmds_cal_src
(
  input  wire logic        ref_clk_i,
  input  wire logic        go_i,
  input  wire logic [15:0] date_i,
  input  wire logic        mid_i,
  output logic             tick_o = 1'b0,
  output logic [6:0]       year_o = 7'h00,
  output logic [3:0]       month_o = 4'h1,
  output logic [4:0]       day_o = 5'h01,
  output logic [4:0]       hour_o = 5'h00,
  output logic [5:0]       min_o = 6'h00
);
  // ************
  // clock reading
  // ************
  // off-midnight readings carry 12:30, so the switch has to ignore them
  always_ff @(posedge ref_clk_i)
  begin
    tick_o <= go_i;
    if (go_i)
    begin
      {year_o, month_o, day_o} <= date_i;
      hour_o <= mid_i ? 5'h00 : 5'h0C;
      min_o <= mid_i ? 6'h00 : 6'h1E;
    end
  end
endmodule : tmds_cal_src

/* File: tmds_cmp.sv */
// date window compare of the twelve-month date switch
// assumes configuration and date are stable registers of the same clock
`timescale 1ns/10ps
module tmds_cmp
  import tmds_pkg::*;
(
  input  wire tmds_date_t cur_i,
  input  wire tmds_date_t on_i,
  input  wire tmds_date_t off_i,
  input  wire logic [2:0] mode_i,
  output logic            active_o,
  output logic            match_o
);

  logic [6:0] y;
  logic [6:0] ony;
  logic [6:0] offy;
  logic [8:0] md;
  logic [8:0] onmd;
  logic [8:0] offmd;
  logic       in_yrs;

  always_comb
  begin
    y      = cur_i[15:YEAR_LSB];
    ony    = on_i[15:YEAR_LSB];
    offy   = off_i[15:YEAR_LSB];
    md     = cur_i[8:0];
    onmd   = on_i[8:0];
    offmd  = off_i[8:0];
    in_yrs = (y >= ony) && (y <= offy);
    active_o = 1'b0;
    match_o  = 1'b0;
    if (mode_i[MODE_MONTHLY])
    begin
      // months ignored, runs to last month
      match_o = in_yrs && (cur_i[4:0] == on_i[4:0]);
      // monthly on day to off day
      if (on_i[4:0] < off_i[4:0])
        active_o = in_yrs && (cur_i[4:0] >= on_i[4:0]) && (cur_i[4:0] < off_i[4:0]);
      else
        active_o = in_yrs && (((cur_i[4:0] >= on_i[4:0]) && !((y == offy) && (cur_i[8:5] == MONTH_MAX)))
                   || ((cur_i[4:0] < off_i[4:0]) && !((y == ony) && (cur_i[8:5] == 4'h1))));
    end
    else if (mode_i[MODE_YEARLY])
    begin
      match_o = in_yrs && (md == onmd);
      // yearly on month-day to off month-day
      if (onmd < offmd)
        active_o = in_yrs && (md >= onmd) && (md < offmd);
      // wrap over new year, stop after last off
      else
        active_o = ((md >= onmd) && (y >= ony) && (y < offy)) || ((md < offmd) && (y > ony) && (y <= offy));
    end
    else
    begin
      // one period from full on to full off
      match_o  = (cur_i == on_i);
      active_o = (cur_i >= on_i) && (cur_i < off_i);
    end
  end

endmodule : tmds_cmp

/* File: tmds_pkg.sv */
// constants and helpers shared by the twelve-month date switch
// assumes dates arrive as binary year offset from 2000, month 1..12, day 1..31
package tmds_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_ON_DATE  = 4'h0;
  localparam logic [3:0] ADDR_OFF_DATE = 4'h4;
  localparam logic [3:0] ADDR_MODE     = 4'h8;
  localparam logic [3:0] ADDR_STATUS   = 4'hC;

  // ****************************************
  // field layout of a date word, mode bits and status bits
  // ****************************************
  localparam int DAY_LSB   = 0;
  localparam int MONTH_LSB = 5;
  localparam int YEAR_LSB  = 9;
  localparam int MODE_MONTHLY = 0;
  localparam int MODE_YEARLY  = 1;
  localparam int MODE_PULSE   = 2;
  localparam int ST_OUT    = 0;
  localparam int ST_LOADED = 1;
  localparam int ST_REJECT = 2;

  // ****************************************
  // limits and reset values
  // ****************************************
  localparam logic [6:0]  YEAR_MAX    = 7'h63;
  localparam logic [3:0]  MONTH_MAX   = 4'hC;
  localparam logic [4:0]  DAY_MAX     = 5'h1F;
  localparam logic [15:0] ON_RST      = 16'h0021;
  localparam logic [15:0] OFF_RST     = 16'h0021;
  localparam logic [2:0]  MODE_RST    = 3'h0;

  typedef logic [15:0] tmds_date_t;

  function automatic tmds_date_t tmds_pack(input logic [6:0] y, input logic [3:0] m, input logic [4:0] d);
    tmds_pack = {y, m, d};
  endfunction : tmds_pack

  // years 2000..2099, month and day in calendar range
  function automatic logic tmds_valid(input tmds_date_t dt);
    tmds_valid = (dt[15:YEAR_LSB] <= YEAR_MAX) && (dt[8:MONTH_LSB] != 4'h0) && (dt[8:MONTH_LSB] <= MONTH_MAX)
                 && (dt[4:DAY_LSB] != 5'h00) && (dt[4:DAY_LSB] <= DAY_MAX);
  endfunction : tmds_valid

endpackage : tmds_pkg

/* File: tmds_pulse.sv */
// edge pulse generator of the twelve-month date switch
// assumes tick_i is a one-clock strobe per program cycle
`timescale 1ns/10ps
module tmds_pulse
  import tmds_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  input  wire logic tick_i,
  input  wire logic match_i,
  input  wire logic once_i,
  input  wire logic clr_i,
  output logic      fire_o,
  output logic      fired_o
);

  typedef struct packed {
    logic prev_match;
    logic fired;
  } tmds_pulse_s;

  tmds_pulse_s st_q;
  tmds_pulse_s st_d;

  always_comb
  begin
    st_d   = st_q;
    fire_o = tick_i && match_i && !st_q.prev_match && !(once_i && st_q.fired);
    if (tick_i)
      st_d.prev_match = match_i;
    if (fire_o)
      st_d.fired = 1'b1;
    else if (clr_i)
      st_d.fired = 1'b0;
    fired_o = st_q.fired;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  AST_PULSE_EDGE: assert property (@(posedge ref_clk_i) disable iff (srst_i) fire_o |-> !st_q.prev_match)
    else $error("pulse fired without a rising match");

endmodule : tmds_pulse

/* File: tmds_top.sv */
// top of the twelve-month date switch with its register port
// assumes calendar inputs and tick come from logic on ref_clk_i
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps

// Summary of operation
// - dates outside 2000-01-01 .. 2099-12-31 are refused
// - output high while the schedule is active, low otherwise
// - switching follows dates taken at 00:00, or at the first tick after reset
// - each date holds year, then month, then day
// - monthly: on at on-day each month, off at off-day
// - on year is first active year, off year last off year
// - yearly: on at on month-day, off at off month-day
// - pulse: high for exactly one program cycle at on date
// - pulse combines with monthly, yearly or single
// - no mode: one continuous period from on date to off date
// - single pulse happens once only
// - yearly window may wrap new year; nothing after final off
// - monthly ignores months, repeats through last month of off year
// - yearly pulse bounded by on year and off year
module tmds_top
  import tmds_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        tick_i,
  input  wire logic [6:0]  cal_year_i,
  input  wire logic [3:0]  cal_month_i,
  input  wire logic [4:0]  cal_day_i,
  input  wire logic [4:0]  cal_hour_i,
  input  wire logic [5:0]  cal_min_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             q_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    tmds_date_t  on_date;
    tmds_date_t  off_date;
    logic [2:0]  mode;
    tmds_date_t  cur;
    logic        loaded;
    logic        reject;
    logic        q;
    logic [31:0] rdata;
  } tmds_top_s;

  tmds_top_s  st_q;
  tmds_top_s  st_d;
  tmds_date_t in_date;
  tmds_date_t sel_date;
  logic       midnight;
  logic       take_date;
  logic       active;
  logic       match;
  logic       fire;
  logic       fired;
  logic       cfg_wr;
  logic       bad_wr;

  // ****************************************
  // date capture
  // ****************************************
  always_comb
  begin
    in_date   = tmds_pack(cal_year_i, cal_month_i, cal_day_i);
    midnight  = (cal_hour_i == 5'h00) && (cal_min_i == 6'h00);
    // first tick after reset loads directly
    take_date = tick_i && (midnight || !st_q.loaded);
    sel_date  = take_date ? in_date : st_q.cur;
  end

  tmds_cmp tmds_cmp_inst (
    .cur_i    (sel_date),
    .on_i     (st_q.on_date),
    .off_i    (st_q.off_date),
    .mode_i   (st_q.mode),
    .active_o (active),
    .match_o  (match)
  );

  // an on-date or mode write rearms the one-shot pulse
  assign cfg_wr = wr_i && ((addr_i == ADDR_ON_DATE) || (addr_i == ADDR_MODE));

  tmds_pulse tmds_pulse_inst (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .tick_i    (tick_i),
    .match_i   (match),
    .once_i    (!st_q.mode[MODE_MONTHLY] && !st_q.mode[MODE_YEARLY]),
    .clr_i     (cfg_wr),
    .fire_o    (fire),
    .fired_o   (fired)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_d       = st_q;
    st_d.rdata = 32'h0000_0000;
    bad_wr     = 1'b0;
    if (take_date)
    begin
      st_d.cur    = in_date;
      st_d.loaded = 1'b1;
    end
    // output follows the schedule each tick
    // pulse lasts until the next tick
    // pulse shares monthly, yearly and single compare
    if (tick_i)
      st_d.q = st_q.mode[MODE_PULSE] ? fire : active;
    if (wr_i)
    begin
      unique case (addr_i)
        ADDR_ON_DATE, ADDR_OFF_DATE:
        begin
          if (tmds_valid(wdata_i[15:0]))
          begin
            if (addr_i == ADDR_ON_DATE)
              st_d.on_date = wdata_i[15:0];
            else
              st_d.off_date = wdata_i[15:0];
          end
          else
            bad_wr = 1'b1;
        end
        ADDR_MODE:
          st_d.mode = wdata_i[2:0];
        ADDR_STATUS:
          if (wdata_i[ST_REJECT])
            st_d.reject = 1'b0;
        default:
          ;
      endcase
    end
    // a refused write wins over a clear in the same cycle
    if (bad_wr)
      st_d.reject = 1'b1;
    if (rd_i)
    begin
      unique case (addr_i)
        ADDR_ON_DATE:  st_d.rdata = {16'h0000, st_q.on_date};
        ADDR_OFF_DATE: st_d.rdata = {16'h0000, st_q.off_date};
        ADDR_MODE:     st_d.rdata = {29'h0000_0000, st_q.mode};
        ADDR_STATUS:   st_d.rdata = {29'h0000_0000, st_q.reject, st_q.loaded, st_q.q};
        default:       st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      st_q          <= '0;
      st_q.on_date  <= ON_RST;
      st_q.off_date <= OFF_RST;
      st_q.mode     <= MODE_RST;
    end
    else
      st_q <= st_d;
  end

  assign q_o     = st_q.q;
  assign rdata_o = st_q.rdata;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  // stored dates in range
  // refused writes never reach the date registers, so this holds at all times
  AST_DATES_VALID: assert property (tmds_valid(st_q.on_date) && tmds_valid(st_q.off_date))
    else $error("stored date out of range");

  AST_STATUS_READ: assert property (rd_i && (addr_i == ADDR_STATUS)
                                    |=> rdata_o[2:0] == {$past(st_q.reject), $past(st_q.loaded), $past(q_o)})
    else $error("status read does not show the output");

  // read data only in the cycle after a read
  AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data without a read");

  AST_PULSE_SRC: assert property (tick_i && st_q.mode[MODE_PULSE] |=> q_o == $past(fire))
    else $error("pulse output not from the pulse edge");

  AST_YEARLY_ON: assert property (tick_i && (st_q.mode == 3'h2) && (sel_date[8:0] == st_q.on_date[8:0])
                                  && (st_q.on_date[8:0] < st_q.off_date[8:0])
                                  && (sel_date[15:YEAR_LSB] >= st_q.on_date[15:YEAR_LSB])
                                  && (sel_date[15:YEAR_LSB] <= st_q.off_date[15:YEAR_LSB]) |=> q_o)
    else $error("yearly output not on at on day");

  // yearly pulses stop after off year
  AST_YEAR_PULSE_END: assert property (tick_i && (st_q.mode == 3'h6)
                                       && (sel_date[15:YEAR_LSB] > st_q.off_date[15:YEAR_LSB]) |=> !q_o)
    else $error("yearly pulse after final year");

  AST_MONTH_END: assert property (tick_i && (st_q.mode == 3'h1)
                                  && (sel_date[15:YEAR_LSB] > st_q.off_date[15:YEAR_LSB]) |=> !q_o)
    else $error("monthly output after final year");

  AST_FIRST_YEAR: assert property (tick_i && (st_q.mode[1:0] != 2'h0) && !st_q.mode[MODE_PULSE]
                                   && (sel_date[15:YEAR_LSB] < st_q.on_date[15:YEAR_LSB]) |=> !q_o)
    else $error("repeating output before first year");

  // output only moves on a program cycle

  AST_Q_ON_TICK: assert property ($changed(q_o) |-> $past(tick_i))
    else $error("output moved without a program cycle");


  AST_RANGE_REJECT: assert property (wr_i && (addr_i == ADDR_ON_DATE) && (wdata_i[15:YEAR_LSB] > YEAR_MAX)
                                     |=> $stable(st_q.on_date) && st_q.reject)
    else $error("out-of-range on date accepted");


  AST_FIELD_ORDER: assert property (wr_i && (addr_i == ADDR_OFF_DATE) && tmds_valid(wdata_i[15:0])
                                    |=> st_q.off_date[15:YEAR_LSB] == $past(wdata_i[15:YEAR_LSB]))
    else $error("off year not in the year field");


  AST_MIDNIGHT: assert property ($changed(st_q.cur) |-> $past(!st_q.loaded || midnight))
    else $error("date taken outside midnight");


  AST_PERIOD: assert property (tick_i && (st_q.mode == 3'h0) |=> q_o == $past(active))
    else $error("single period output wrong");


  AST_PULSE_ONE: assert property (st_q.mode[MODE_PULSE] && tick_i && q_o && !cfg_wr && !match |=> !q_o)
    else $error("pulse longer than one program cycle");


  AST_SINGLE_ONCE: assert property (fired && (st_q.mode == 3'h4) && !cfg_wr |=> !fire)
    else $error("single pulse repeated");


  AST_YEAR_END: assert property (tick_i && st_q.mode[MODE_YEARLY] && !st_q.mode[MODE_PULSE]
                                 && (sel_date[15:YEAR_LSB] > st_q.off_date[15:YEAR_LSB]) |=> !q_o)
    else $error("yearly output after final year");


  AST_MONTHLY_ON: assert property (tick_i && (st_q.mode == 3'h1) && (sel_date[4:0] == st_q.on_date[4:0])
                                   && (st_q.on_date[4:0] < st_q.off_date[4:0])
                                   && (sel_date[15:YEAR_LSB] >= st_q.on_date[15:YEAR_LSB])
                                   && (sel_date[15:YEAR_LSB] <= st_q.off_date[15:YEAR_LSB]) |=> q_o)
    else $error("monthly output not on at on day");

  COV_SINGLE: cover property (tick_i && (st_q.mode == 3'h0) ##1 q_o);
  COV_YEARLY_WRAP: cover property (st_q.mode[MODE_YEARLY] && (st_q.on_date[8:0] > st_q.off_date[8:0]) && q_o);
  COV_PULSE: cover property (fire ##1 q_o);
  COV_REJECT: cover property (bad_wr);

endmodule : tmds_top
